// file: bob_core.sv
// Contract
// - A read from a write-only register yields all ones, so read-modify-write sees those bits set.
// - Set, clear and invert read the whole byte, change one bit, and write the whole byte back.
// - The bit number may be a 3-bit immediate picking one of eight bits.
// - Set, clear, invert and test may take the bit number from a general register instead.
// - The operand may be a register, a byte addressed through a register, or an 8-bit absolute address.
// - Indirect and absolute forms carry a fixed all-zero nibble, anything else is illegal.
// - Inverted-operand logic and inverted load/store accept only an immediate bit number.
// - A conditional branch tests the condition field against C, Z, N and V per the standard pair table.
module bob_core (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Bit instruction request
  input  wire logic                 bit_valid,
  input  bob_pkg::bob_bitreq_t      bit_req,
  output logic                      bit_done,
  output logic                      bit_illegal,
  output logic [7:0]                reg_result,
  output logic                      reg_we,
  // Flow request
  input  wire logic                 flow_valid,
  input  bob_pkg::bob_flowreq_t     flow_req,
  // Flags in and out
  input  bob_pkg::bob_flags_t       flags_in,
  output bob_pkg::bob_flags_t       flags_out,
  // Byte bus
  output logic                      bus_rd,
  output logic                      bus_wr,
  output logic [15:0]               bus_addr,
  output logic [7:0]                bus_wdata,
  input  wire logic [7:0]           bus_rdata,
  input  wire logic                 bus_ack,
  input  wire logic                 bus_write_only,
  // Program counter
  output logic [15:0]               pc,
  output logic                      taken
);

  typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE} bob_state_t;

  bob_state_t          state_reg, state_next;
  bob_pkg::bob_bitreq_t req_reg, req_next;
  logic [15:0]         addr_reg, addr_next;
  logic [7:0]          wdata_reg, wdata_next;
  logic [7:0]          result_reg, result_next;
  logic                reg_we_reg, reg_we_next;
  logic                done_reg, done_next;
  logic                ill_reg, ill_next;
  bob_pkg::bob_flags_t flags_reg, flags_next;
  logic [15:0]         pc_reg, pc_next;
  logic [15:0]         ret_reg, ret_next;
  logic                taken_reg, taken_next;

  logic [2:0]          sel;
  logic                legal;
  logic [7:0]          rd_byte;
  logic [7:0]          mod_byte;
  logic                bitv;
  logic                writes;
  bob_pkg::bob_flags_t fl_mod;
  logic                cond;

  ////////////////////////////////////////////////////////////////////////////
  // Bit selection and legality
  always_comb
  begin
    sel   = bit_req.bit_from_reg ? bit_req.bit_reg[2:0] : bit_req.bit_imm;
    legal = 1'b1;
    if (bit_req.bit_from_reg && !(bit_req.op inside {bob_pkg::BOB_SET, bob_pkg::BOB_CLR,
                                                      bob_pkg::BOB_NOT, bob_pkg::BOB_TST}))
    begin
      legal = 1'b0;
    end
    if (bit_req.opd != bob_pkg::BOB_OPD_REG && bit_req.low_nibble != bob_pkg::BOB_FIXED_NIB)
    begin
      legal = 1'b0;
    end
  end

  // Modify stage works on the latched request
  always_comb
  begin
    rd_byte  = (req_reg.opd == bob_pkg::BOB_OPD_REG) ? req_reg.reg_val : bus_rdata;
    if (req_reg.opd != bob_pkg::BOB_OPD_REG && bus_write_only)
    begin
      rd_byte = bob_pkg::BOB_WO_READ;
    end
    bitv     = rd_byte[wdata_reg[2:0]];
    mod_byte = rd_byte;
    fl_mod   = flags_reg;
    writes   = 1'b1;
    case (req_reg.op)
      bob_pkg::BOB_SET:  mod_byte[wdata_reg[2:0]] = 1'b1;
      bob_pkg::BOB_CLR:  mod_byte[wdata_reg[2:0]] = 1'b0;
      bob_pkg::BOB_NOT:  mod_byte[wdata_reg[2:0]] = ~bitv;
      bob_pkg::BOB_ST:   mod_byte[wdata_reg[2:0]] = flags_reg.c;
      bob_pkg::BOB_IST:  mod_byte[wdata_reg[2:0]] = ~flags_reg.c;
      default:           writes = 1'b0;
    endcase
    case (req_reg.op)
      bob_pkg::BOB_TST:  fl_mod.z = ~bitv;
      bob_pkg::BOB_AND:  fl_mod.c = flags_reg.c & bitv;
      bob_pkg::BOB_OR:   fl_mod.c = flags_reg.c | bitv;
      bob_pkg::BOB_XOR:  fl_mod.c = flags_reg.c ^ bitv;
      bob_pkg::BOB_LD:   fl_mod.c = bitv;
      bob_pkg::BOB_IAND: fl_mod.c = flags_reg.c & ~bitv;
      bob_pkg::BOB_IOR:  fl_mod.c = flags_reg.c | ~bitv;
      bob_pkg::BOB_IXOR: fl_mod.c = flags_reg.c ^ ~bitv;
      bob_pkg::BOB_ILD:  fl_mod.c = ~bitv;
      default:           fl_mod.c = flags_reg.c;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition evaluation
  always_comb
  begin
    case (flow_req.condition_field[3:1])
      3'h0:    cond = 1'b1;
      3'h1:    cond = ~(flags_reg.c | flags_reg.z);
      3'h2:    cond = ~flags_reg.c;
      3'h3:    cond = ~flags_reg.z;
      3'h4:    cond = ~flags_reg.v;
      3'h5:    cond = ~flags_reg.n;
      3'h6:    cond = ~(flags_reg.n ^ flags_reg.v);
      default: cond = ~(flags_reg.z | (flags_reg.n ^ flags_reg.v));
    endcase
    if (flow_req.condition_field[0])
    begin
      cond = ~cond;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    state_next  = state_reg;
    req_next    = req_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    result_next = result_reg;
    reg_we_next = 1'b0;
    done_next   = 1'b0;
    ill_next    = 1'b0;
    flags_next  = flags_reg;
    pc_next     = pc_reg;
    ret_next    = ret_reg;
    taken_next  = 1'b0;
    case (state_reg)
      S_IDLE:
      begin
        // Flags follow the core unless a bit op owns them
        flags_next = flags_in;
        if (bit_valid)
        begin
          if (!legal)
          begin
            ill_next  = 1'b1;
            done_next = 1'b1;
          end
          else
          begin
            req_next   = bit_req;
            state_next = S_READ;
            // Low bits carry the bit number in register form
            case (bit_req.opd)
              bob_pkg::BOB_OPD_IND: addr_next = bit_req.ind_addr;
              bob_pkg::BOB_OPD_ABS: addr_next = bob_pkg::BOB_ABS_BASE | {8'h00, bit_req.abs_addr};
              default:              addr_next = {13'h0000, sel};
            endcase
            wdata_next = {5'h00, sel};
          end
        end
        else if (flow_valid)
        begin
          pc_next = pc_reg + bob_pkg::BOB_INSTR_BYTES;
          case (flow_req.kind)
            bob_pkg::BOB_FL_BCC:
            begin
              if (cond)
              begin
                pc_next    = pc_reg + bob_pkg::BOB_INSTR_BYTES + flow_req.disp;
                taken_next = 1'b1;
              end
            end
            bob_pkg::BOB_FL_JMP:
            begin
              pc_next    = flow_req.target;
              taken_next = 1'b1;
            end
            bob_pkg::BOB_FL_JSR:
            begin
              ret_next   = pc_reg + bob_pkg::BOB_INSTR_BYTES;
              pc_next    = flow_req.target;
              taken_next = 1'b1;
            end
            bob_pkg::BOB_FL_BSR:
            begin
              ret_next   = pc_reg + bob_pkg::BOB_INSTR_BYTES;
              pc_next    = pc_reg + bob_pkg::BOB_INSTR_BYTES + flow_req.disp;
              taken_next = 1'b1;
            end
            default:
            begin
              pc_next    = ret_reg;
              taken_next = 1'b1;
            end
          endcase
        end
      end
      S_READ:
      begin
        if (req_reg.opd == bob_pkg::BOB_OPD_REG || bus_ack)
        begin
          // Bit index parked in wdata until the byte arrives
          flags_next = fl_mod;
          if (!writes)
          begin
            done_next  = 1'b1;
            state_next = S_IDLE;
          end
          else if (req_reg.opd == bob_pkg::BOB_OPD_REG)
          begin
            result_next = mod_byte;
            reg_we_next = 1'b1;
            done_next   = 1'b1;
            state_next  = S_IDLE;
          end
          else
          begin
            wdata_next = mod_byte;
            state_next = S_WRITE;
          end
        end
      end
      default:
      begin
        if (bus_ack)
        begin
          done_next  = 1'b1;
          state_next = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_reg  <= S_IDLE;
      req_reg    <= '0;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      result_reg <= '0;
      reg_we_reg <= 1'b0;
      done_reg   <= 1'b0;
      ill_reg    <= 1'b0;
      flags_reg  <= '0;
      pc_reg     <= bob_pkg::BOB_PC_RESET;
      ret_reg    <= bob_pkg::BOB_SP_RESET;
      taken_reg  <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      req_reg    <= req_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      result_reg <= result_next;
      reg_we_reg <= reg_we_next;
      done_reg   <= done_next;
      ill_reg    <= ill_next;
      flags_reg  <= flags_next;
      pc_reg     <= pc_next;
      ret_reg    <= ret_next;
      taken_reg  <= taken_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Register form never touches the bus
  assign bus_rd      = (state_reg == S_READ) && (req_reg.opd != bob_pkg::BOB_OPD_REG);
  assign bus_wr      = (state_reg == S_WRITE);
  assign bus_addr    = addr_reg;
  assign bus_wdata   = wdata_reg;
  assign bit_done    = done_reg;
  assign bit_illegal = ill_reg;
  assign reg_result  = result_reg;
  assign reg_we      = reg_we_reg;
  assign flags_out   = flags_reg;
  assign pc          = pc_reg;
  assign taken       = taken_reg;

endmodule : bob_core

// file: bob_core_checker.sv
module bob_core_checker (
  // Clock and reset
  input wire logic             clk,
  input wire logic             rstn,
  // Bit side
  input wire logic             bit_valid,
  input wire logic             bit_done,
  input wire logic             bit_illegal,
  input wire logic             reg_we,
  // Byte bus
  input wire logic             bus_rd,
  input wire logic             bus_wr,
  input wire logic [15:0]      bus_addr,
  input wire logic [7:0]       bus_wdata,
  input wire logic [7:0]       bus_rdata,
  input wire logic             bus_ack,
  input wire logic             bus_write_only,
  // Flow side
  input wire logic             flow_valid,
  input bob_pkg::bob_flowreq_t flow_req,
  input wire logic             taken
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  property p_ill_done; bit_illegal |-> bit_done && !bus_rd && !bus_wr; endproperty
  a_ill_done: assert property (p_ill_done) else $error("refusal without done or with bus");
  // Write-only reads count as all ones, so at most one bit may differ
  property p_rmw_bit;
    bus_rd && bus_ack |=> !bus_wr ||
      $countones(bus_wdata ^ ($past(bus_write_only) ? bob_pkg::BOB_WO_READ : $past(bus_rdata))) <= 1;
  endproperty
  a_rmw_bit: assert property (p_rmw_bit) else $error("write back changes more than one bit");
  property p_wr_addr; bus_rd && bus_ack |=> !bus_wr || $stable(bus_addr); endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write back to another address");
  property p_wr_hold; bus_wr && !bus_ack |=> bus_wr && $stable(bus_addr) && $stable(bus_wdata); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write dropped before ack");
  property p_rd_hold; bus_rd && !bus_ack |=> bus_rd && $stable(bus_addr); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read dropped before ack");
  property p_wr_end; bus_wr && bus_ack |=> !bus_wr && bit_done; endproperty
  a_wr_end: assert property (p_wr_end) else $error("no done after write ack");
  property p_rd_excl; !(bus_rd && bus_wr); endproperty
  a_rd_excl: assert property (p_rd_excl) else $error("read and write together");
  property p_always;
    flow_valid && !bit_valid && flow_req.kind == bob_pkg::BOB_FL_BCC && flow_req.condition_field == 4'h0 |=> taken;
  endproperty
  a_always: assert property (p_always) else $error("always branch not taken");
  property p_never;
    flow_valid && !bit_valid && flow_req.kind == bob_pkg::BOB_FL_BCC && flow_req.condition_field == 4'h1 |=> !taken;
  endproperty
  a_never: assert property (p_never) else $error("never branch taken");
  ////////////////////////////////////////
  c_wo: cover property (bus_rd && bus_ack && bus_write_only);
  c_ill: cover property (bit_illegal);
  c_tk: cover property (taken);
  c_we: cover property (reg_we);
endmodule : bob_core_checker

bind bob_core bob_core_checker u_chk (.clk(clk), .rstn(rstn), .bit_valid(bit_valid), .bit_done(bit_done),
  .bit_illegal(bit_illegal), .reg_we(reg_we), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_write_only(bus_write_only),
  .flow_valid(flow_valid), .flow_req(flow_req), .taken(taken));

// file: bob_pkg.sv
package bob_pkg;

  // Bit operation kinds
  typedef enum logic [3:0] {
    BOB_SET, BOB_CLR, BOB_NOT, BOB_TST,
    BOB_AND, BOB_OR, BOB_XOR, BOB_LD, BOB_ST,
    BOB_IAND, BOB_IOR, BOB_IXOR, BOB_ILD, BOB_IST
  } bob_op_t;

  // Operand addressing forms
  typedef enum logic [1:0] {
    BOB_OPD_REG, BOB_OPD_IND, BOB_OPD_ABS
  } bob_opd_t;

  // Flow control kinds
  typedef enum logic [2:0] {
    BOB_FL_BCC, BOB_FL_JMP, BOB_FL_JSR, BOB_FL_BSR, BOB_FL_RTS
  } bob_flow_t;

  typedef struct packed {
    logic        c;
    logic        z;
    logic        n;
    logic        v;
  } bob_flags_t;

  // Decoded bit instruction request
  typedef struct packed {
    bob_op_t     op;
    bob_opd_t    opd;
    logic        bit_from_reg;
    logic [2:0]  bit_imm;
    logic [7:0]  bit_reg;
    logic [3:0]  low_nibble;
    logic [7:0]  reg_val;
    logic [15:0] ind_addr;
    logic [7:0]  abs_addr;
  } bob_bitreq_t;

  // Flow request
  typedef struct packed {
    bob_flow_t   kind;
    logic [3:0]  condition_field;
    logic [15:0] target;
    logic [15:0] disp;
  } bob_flowreq_t;

  localparam logic [7:0]  BOB_WO_READ     = 8'hff;
  localparam logic [15:0] BOB_ABS_BASE    = 16'hff00;
  localparam logic [3:0]  BOB_FIXED_NIB   = 4'h0;
  localparam logic [15:0] BOB_PC_RESET    = 16'h0000;
  localparam logic [15:0] BOB_INSTR_BYTES = 16'h0002;
  localparam logic [15:0] BOB_SP_RESET    = 16'h0000;

endpackage : bob_pkg

// file: tb_bob_core.sv
module tb_bob_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk = 1'b0, rstn = 1'b0, bit_valid = 1'b0, flow_valid = 1'b0;
  logic                  bus_ack = 1'b0, bus_write_only = 1'b0;
  logic [7:0]            bus_rdata = 8'h00, reg_result, bus_wdata, got_res, got_wd;
  logic [15:0]           bus_addr, pc, got_ra, got_wa, exp_pc = 16'h0000, ret_pc = 16'h0000;
  logic                  bit_done, bit_illegal, reg_we, bus_rd, bus_wr, taken, got_ill;
  bob_pkg::bob_bitreq_t  bit_req = '0;
  bob_pkg::bob_flowreq_t flow_req = '0;
  bob_pkg::bob_flags_t   flags_in = '0, flags_out, got_fl;
  int                    n_fail = 0, num_checks = 0, n_rd, n_wr;

  always #4 clk = ~clk;

  bob_core u_dut (.clk(clk), .rstn(rstn), .bit_valid(bit_valid), .bit_req(bit_req), .bit_done(bit_done),
    .bit_illegal(bit_illegal), .reg_result(reg_result), .reg_we(reg_we), .flow_valid(flow_valid),
    .flow_req(flow_req), .flags_in(flags_in), .flags_out(flags_out), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .bus_write_only(bus_write_only), .pc(pc), .taken(taken));
  ////////////////////////////////////////
  task give_verdict;
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // With the bit number from a register the immediate differs from the register bit so a wrong source shows
  function bob_pkg::bob_bitreq_t mk(bob_pkg::bob_op_t op, bob_pkg::bob_opd_t fm, logic fr, logic [2:0] b,
                                    logic [3:0] nib, logic [7:0] rv);
    mk = '{op, fm, fr, fr ? ~b : b, {5'h1f, b}, nib, rv, 16'h1234, 8'h5c};
  endfunction : mk

  function logic cond(input logic [3:0] cc, input bob_pkg::bob_flags_t f);
    logic [7:0] t;
    t = {f.z | (f.n ^ f.v), f.n ^ f.v, f.n, f.v, f.z, f.c, f.c | f.z, 1'b0};
    cond = t[cc[3:1]] == cc[0];
  endfunction : cond

  // Bench plays the bus: ack one cycle after each request, data scrambled once released
  task run_bit(input bob_pkg::bob_bitreq_t r, input logic [7:0] rd, input logic wo);
    int i;
    logic dn;
    @(posedge clk);
    bit_req <= r;
    bit_valid <= 1'b1;
    @(posedge clk);
    bit_valid <= 1'b0;
    dn = 1'b0;
    n_rd = 0;
    n_wr = 0;
    for (i = 0; i < 40 && !dn; i++)
    begin
      @(posedge clk);
      if (reg_we === 1'b1)
        got_res = reg_result;
      if (bit_done === 1'b1)
      begin
        dn = 1'b1;
        got_ill = bit_illegal;
        got_fl = flags_out;
      end
      if (bus_ack)
      begin
        bus_ack <= 1'b0;
        bus_rdata <= ~rd;
        bus_write_only <= 1'b0;
      end
      else if (bus_rd === 1'b1 || bus_wr === 1'b1)
      begin
        bus_ack <= 1'b1;
        bus_rdata <= rd;
        bus_write_only <= wo;
        n_rd += bus_rd;
        n_wr += bus_wr;
        if (bus_rd)
          got_ra = bus_addr;
        else
          got_wa = bus_addr;
        got_wd = bus_wdata;
      end
    end
    if (!dn)
    begin
      chk("bit_done", 16'h1, 16'h0);
      give_verdict;
    end
  endtask : run_bit

  task run_flow(input bob_pkg::bob_flow_t k, input logic [3:0] cc, input logic [3:0] fb);
    bob_pkg::bob_flags_t fl;
    logic [15:0] e;
    fl = bob_pkg::bob_flags_t'(fb);
    e = exp_pc + bob_pkg::BOB_INSTR_BYTES;
    @(posedge clk);
    flags_in <= fl;
    flow_req <= '{k, cc, 16'h0400, 16'h0010};
    @(posedge clk);
    flow_valid <= 1'b1;
    @(posedge clk);
    flow_valid <= 1'b0;
    @(posedge clk);
    case (k)
      bob_pkg::BOB_FL_BCC: e = cond(cc, fl) ? e + 16'h0010 : e;
      bob_pkg::BOB_FL_JMP: e = 16'h0400;
      bob_pkg::BOB_FL_JSR: {ret_pc, e} = {e, 16'h0400};
      bob_pkg::BOB_FL_BSR: {ret_pc, e} = {e, e + 16'h0010};
      default: e = ret_pc;
    endcase
    if (k == bob_pkg::BOB_FL_BCC)
      chk("taken", {15'h0, cond(cc, fl)}, {15'h0, taken});
    chk("pc", e, pc);
    exp_pc = e;
  endtask : run_flow
  ////////////////////////////////////////
  task t_reg_rmw;
    int o, b, f;
    logic [7:0] e;
    for (o = 0; o < 3; o++)
      for (b = 0; b < 8; b += 7)
        for (f = 0; f < 2; f++)
        begin
          run_bit(mk(bob_pkg::bob_op_t'(o), bob_pkg::BOB_OPD_REG, f[0], b[2:0], 4'h0, 8'h5a), 8'h00, 1'b0);
          e = o == 0 ? 8'h5a | (8'h01 << b) : o == 1 ? 8'h5a & ~(8'h01 << b) : 8'h5a ^ (8'h01 << b);
          chk("reg_result", {8'h00, e}, {8'h00, got_res});
          chk("refused", 16'h0, {15'h0, got_ill});
        end
  endtask : t_reg_rmw

  task t_misc;
    int o;
    run_bit(mk(bob_pkg::BOB_TST, bob_pkg::BOB_OPD_IND, 1'b1, 3'd1, 4'h0, 8'h00), 8'h5a, 1'b0);
    chk("tst_z", 16'h0, {15'h0, got_fl.z});
    chk("tst_writes", 16'h0, n_wr[15:0]);
    run_bit(mk(bob_pkg::BOB_ILD, bob_pkg::BOB_OPD_REG, 1'b0, 3'd0, 4'h0, 8'h5a), 8'h00, 1'b0);
    chk("ild_c", 16'h1, {15'h0, got_fl.c});
    run_bit(mk(bob_pkg::BOB_CLR, bob_pkg::BOB_OPD_IND, 1'b0, 3'd0, 4'h0, 8'h00), 8'h3f, 1'b1);
    chk("rd_addr", 16'h1234, got_ra);
    chk("wr_addr", 16'h1234, got_wa);
    chk("wr_data", 16'h00fe, {8'h00, got_wd});
    chk("writes", 16'h1, n_wr[15:0]);
    run_bit(mk(bob_pkg::BOB_SET, bob_pkg::BOB_OPD_ABS, 1'b1, 3'd7, 4'h0, 8'h00), 8'h01, 1'b0);
    chk("abs_addr", bob_pkg::BOB_ABS_BASE | 16'h005c, got_wa);
    chk("abs_data", 16'h0081, {8'h00, got_wd});
    for (o = 9; o < 14; o++)
    begin
      run_bit(mk(bob_pkg::bob_op_t'(o), bob_pkg::BOB_OPD_REG, 1'b1, 3'd2, 4'h0, 8'h00), 8'h00, 1'b0);
      chk("refused", 16'h1, {15'h0, got_ill});
    end
    run_bit(mk(bob_pkg::BOB_SET, bob_pkg::BOB_OPD_ABS, 1'b0, 3'd2, 4'h8, 8'h00), 8'h00, 1'b0);
    chk("nibble", 16'h1, {15'h0, got_ill});
    chk("bus_reads", 16'h0, n_rd[15:0]);
  endtask : t_misc

  // Carry ops and stores, both carry values on a clear and a set bit
  task t_carry;
    int o, b, c;
    logic v, ec;
    logic [7:0] e;
    for (o = 4; o < 14; o++)
      for (b = 0; b < 2; b++)
        for (c = 0; c < 2; c++)
        begin
          flags_in <= '{c[0], 1'b0, 1'b0, 1'b0};
          run_bit(mk(bob_pkg::bob_op_t'(o), bob_pkg::BOB_OPD_REG, 1'b0, b[2:0], 4'h0, 8'h5a), 8'h00, 1'b0);
          // Bit 0 of the operand is clear, bit 1 is set
          v = b[0];
          case (o)
            4:       ec = c[0] & v;
            5:       ec = c[0] | v;
            6:       ec = c[0] ^ v;
            7:       ec = v;
            9:       ec = c[0] & ~v;
            10:      ec = c[0] | ~v;
            11:      ec = c[0] ^ ~v;
            12:      ec = ~v;
            default: ec = c[0];
          endcase
          if (o == 8 || o == 13)
          begin
            e = 8'h5a;
            e[b] = (o == 8) ? c[0] : ~c[0];
            chk("store_byte", {8'h00, e}, {8'h00, got_res});
          end
          chk("carry", {15'h0, ec}, {15'h0, got_fl.c});
        end
  endtask : t_carry

  task t_flow;
    int c, f;
    for (c = 0; c < 16; c++)
      for (f = 0; f < 16; f++)
        run_flow(bob_pkg::BOB_FL_BCC, c[3:0], f[3:0]);
    run_flow(bob_pkg::BOB_FL_JMP, 4'h0, 4'h0);
    run_flow(bob_pkg::BOB_FL_JSR, 4'h0, 4'h0);
    run_flow(bob_pkg::BOB_FL_RTS, 4'h0, 4'h0);
    run_flow(bob_pkg::BOB_FL_BSR, 4'h0, 4'h0);
    run_flow(bob_pkg::BOB_FL_RTS, 4'h0, 4'h0);
  endtask : t_flow

  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("reset_pc", bob_pkg::BOB_PC_RESET, pc);
    t_reg_rmw;
    t_misc;
    t_carry;
    t_flow;
    give_verdict;
  end
endmodule : tb_bob_core
